// file: shared/hpc_pkg.sv
package hpc_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int   HPC_DATA_W       = 8;
    localparam logic HPC_SEL_RST      = 1'b0;
    localparam logic HPC_INT_RST      = 1'b1;
    localparam logic HPC_RDY_RST      = 1'b0;
    localparam logic HPC_HOLD_EN_RST  = 1'b0;

    typedef enum logic [1:0] {
        HPC_ST_RESET,
        HPC_ST_SAMPLE,
        HPC_ST_RUN
    } hpc_state_e;

endpackage

// file: tb/hpc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Host and board side
// --------------------------------
module hpc_host_model (
    input  wire logic ref_clk,                // Clock
    input  wire logic active,                 // Host toggles strobe
    input  wire logic sel,                    // Board strap level
    output logic      host_port_select_strap, // Strap pin
    output logic      host_strobe_in          // Strobe pin
);
    assign host_port_select_strap = sel;
    initial host_strobe_in = 1'b1;
    always @(posedge ref_clk) host_strobe_in <= active ? !host_strobe_in : 1'b1;
endmodule
`default_nettype wire

// file: tb/hpc_host_port_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Pin control checks
// --------------------------------
module hpc_chk (
    input wire logic ref_clk, rst_b, device_reset_in, host_port_select_strap,
    input wire logic test_reset_in, emulator_line_zero, core_data_oe,
    input wire logic emulator_line_one_or_disable, host_data_lines_oe,
    input wire logic host_data_hold_oe, host_ready_oe, host_interrupt_out,
    input wire logic host_interrupt_oe, port_selected, host_input_pullup_en,
    input wire logic strap_pulldown_en, host_strobe_seen
);
    wire logic dis = !test_reset_in && emulator_line_zero
                     && !emulator_line_one_or_disable;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    property p_rdy_off; dis |-> !host_ready_oe; endproperty
    a_rdy_off: assert property (p_rdy_off) else $error("ready oe");
    property p_int_rst; !device_reset_in && !$past(device_reset_in) && !dis
        |-> host_interrupt_oe && host_interrupt_out; endproperty
    a_int_rst: assert property (p_int_rst) else $error("irq rst");
    property p_int_off; dis |-> !host_interrupt_oe; endproperty
    a_int_off: assert property (p_int_off) else $error("irq oe");
    property p_pd; strap_pulldown_en == !device_reset_in; endproperty
    a_pd: assert property (p_pd) else $error("pulldown");
    property p_cap; $rose(device_reset_in) ##1 (device_reset_in &&
        $stable(host_port_select_strap))[*3]
        |=> port_selected == $past(host_port_select_strap); endproperty
    a_cap: assert property (p_cap) else $error("capture");
    property p_keep; device_reset_in[*4] |=> $stable(port_selected); endproperty
    a_keep: assert property (p_keep) else $error("sel moved");
    property p_desel; !port_selected && !$past(port_selected) && device_reset_in
        && $past(device_reset_in, 3) |-> !host_ready_oe && !host_strobe_seen
        && host_input_pullup_en; endproperty
    a_desel: assert property (p_desel) else $error("desel");
    property p_doe; host_data_lines_oe |-> $past(core_data_oe) && !dis;
    endproperty
    a_doe: assert property (p_doe) else $error("data oe");
    property p_hold; host_data_hold_oe |-> !host_data_lines_oe && !dis;
    endproperty
    a_hold: assert property (p_hold) else $error("holder");
endmodule
bind hpc_host_port_ctrl hpc_chk i_hpc_chk (.*);
`default_nettype wire

// file: tb/hpc_host_port_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Scenarios
// --------------------------------
module hpc_host_port_ctrl_tb_top;
    import hpc_pkg::*;
    logic ref_clk, rst_b, device_reset_in, test_reset_in, emulator_line_zero;
    logic emulator_line_one_or_disable, core_ready, core_interrupt, active;
    logic core_data_oe, holder_sw_enable, sel, host_data_lines_oe;
    logic host_data_hold_oe, host_ready_out, host_ready_oe, host_interrupt_out;
    logic host_interrupt_oe, port_selected, host_input_pullup_en;
    logic strap_pulldown_en, host_strobe_seen;
    logic [7:0] core_data_out, host_data_lines_in, host_data_lines_out;
    logic [7:0] host_data_hold_val;
    wire logic host_port_select_strap, host_strobe_in;
    int errors, comparisons;
    hpc_host_port_ctrl i_hpc_host_port_ctrl (.*);
    hpc_host_model i_hpc_host_model (.ref_clk, .active, .sel,
        .host_port_select_strap, .host_strobe_in);
    assign host_data_lines_in = host_data_lines_oe ? host_data_lines_out
        : host_data_hold_oe ? host_data_hold_val : 8'ha5;
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = !ref_clk;
    end
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic w(int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic boot(logic s);
        @(posedge ref_clk);
        device_reset_in <= 1'b0;
        sel <= s;
        w(2);
        chk("irq", 8'h03, {host_interrupt_oe, host_interrupt_out});
        chk("pd", 8'h01, strap_pulldown_en);
        @(posedge ref_clk);
        device_reset_in <= 1'b1;
        w(4);
        chk("pd", 8'h00, strap_pulldown_en);
        chk("sel", s, port_selected);
    endtask
    task automatic t_sel;
        boot(1'b1);
        @(posedge ref_clk);
        sel <= 1'b0;
        core_data_oe <= 1'b1;
        core_interrupt <= 1'b1;
        w(3);
        chk("sel", 8'h01, port_selected);
        chk("irq", 8'h03, {host_interrupt_oe, host_interrupt_out});
        chk("stb", 8'h01, host_strobe_seen);
        chk("rdy", 8'h03, {host_ready_oe, host_ready_out});
        chk("data", 8'h5a, host_data_lines_out);
        chk("doe", 8'h01, host_data_lines_oe);
        @(posedge ref_clk);
        core_data_oe <= 1'b0;
        w(2);
        chk("doe", 8'h00, host_data_lines_oe);
        chk("bus", 8'h5a, host_data_lines_in);
        @(posedge ref_clk);
        emulator_line_one_or_disable <= 1'b0;
        w(1);
        chk("off", 8'h00, {host_ready_oe, host_interrupt_oe});
        chk("hoe", 8'h00, host_data_hold_oe);
        @(posedge ref_clk);
        emulator_line_one_or_disable <= 1'b1;
    endtask
    task automatic t_desel;
        boot(1'b0);
        @(posedge ref_clk);
        active <= 1'b1;
        holder_sw_enable <= 1'b0;
        w(4);
        chk("pu", 8'h03, {host_input_pullup_en, host_data_hold_oe});
        chk("rdy", 8'h00, {host_ready_oe, host_strobe_seen});
    endtask
    task automatic summarize;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {rst_b, test_reset_in, core_interrupt, core_data_oe, active} = '0;
        {device_reset_in, emulator_line_zero, core_ready, sel} = 4'h7;
        {emulator_line_one_or_disable, holder_sw_enable} = 2'b11;
        core_data_out = 8'h5a;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_sel();
        t_desel();
        summarize();
    end
    initial begin
        #50000;
        errors++;
        summarize();
    end
endmodule
`default_nettype wire

// file: verilog/hpc_bus_holder.sv
`timescale 1ns/1ps
`default_nettype none

module hpc_bus_holder #(
    parameter int W = 8
) (
    input  wire logic         ref_clk,     // Clock
    input  wire logic         rst_b,       // Async reset, active low
    input  wire logic         hold_en,     // Holder enabled
    input  wire logic         pad_oe,      // Line driven by the port itself
    input  wire logic [W-1:0] pad_level,   // Level seen on the lines
    output logic      [W-1:0] hold_val,    // Level the holder keeps
    output logic              hold_oe      // Holder drives the lines
);
    import hpc_pkg::*;

    logic [W-1:0] last_q;
    logic [W-1:0] last_d;

    // ------------------------------------------------------------
    // Last driven level
    // ------------------------------------------------------------
    always_comb begin
        last_d = last_q;
        if (pad_oe) begin
            last_d = pad_level;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_q <= '0;
        end else begin
            last_q <= last_d;
        end
    end

    assign hold_val = last_q;
    assign hold_oe  = hold_en & ~pad_oe;

endmodule

`default_nettype wire

// file: verilog/hpc_host_port_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module hpc_host_port_ctrl
    import hpc_pkg::*;
#(
    parameter int DATA_W = hpc_pkg::HPC_DATA_W
) (
    input  wire logic              ref_clk,                 // Clock
    input  wire logic              rst_b,                   // Async reset
    input  wire logic              device_reset_in,         // Reset pin, low
    input  wire logic              host_port_select_strap,  // Select strap
    input  wire logic              test_reset_in,           // Test reset
    input  wire logic              emulator_line_zero,      // Emulator 0
    input  wire logic              emulator_line_one_or_disable, // Disable
    input  wire logic              host_strobe_in,          // Host strobe
    input  wire logic              core_ready,              // Core ready
    input  wire logic              core_interrupt,          // Core irq req
    input  wire logic              core_data_oe,            // Core outputs
    input  wire logic [DATA_W-1:0] core_data_out,           // Core data
    input  wire logic              holder_sw_enable,        // Holder on
    input  wire logic [DATA_W-1:0] host_data_lines_in,      // Data pins in
    output logic      [DATA_W-1:0] host_data_lines_out,     // Data pins out
    output logic                   host_data_lines_oe,      // Data pins oe
    output logic      [DATA_W-1:0] host_data_hold_val,      // Holder level
    output logic                   host_data_hold_oe,       // Holder drive
    output logic                   host_ready_out,          // Ready value
    output logic                   host_ready_oe,           // Ready drive
    output logic                   host_interrupt_out,      // Irq value
    output logic                   host_interrupt_oe,       // Irq drive
    output logic                   port_selected,           // Captured sel
    output logic                   host_input_pullup_en,    // Input pullups
    output logic                   strap_pulldown_en,       // Strap pulldown
    output logic                   host_strobe_seen         // Accepted strobe
);
    import hpc_pkg::*;

    hpc_state_e        state_q;
    hpc_state_e        state_d;
    logic              sel_q;
    logic              sel_d;
    logic              int_q;
    logic              int_d;
    logic              rdy_q;
    logic              rdy_d;
    logic [DATA_W-1:0] dout_q;
    logic [DATA_W-1:0] dout_d;
    logic              doe_q;
    logic              doe_d;
    logic              strobe_q;
    logic              strobe_d;
    logic              off_cond;
    logic              hold_on;

    // ------------------------------------------------------------
    // Output disable condition
    // ------------------------------------------------------------
    assign off_cond = ~test_reset_in & emulator_line_zero
                    & ~emulator_line_one_or_disable;

    // ------------------------------------------------------------
    // Strap capture and port control
    // ------------------------------------------------------------
    always_comb begin
        state_d  = state_q;
        sel_d    = sel_q;
        int_d    = int_q;
        rdy_d    = rdy_q;
        dout_d   = dout_q;
        doe_d    = 1'b0;
        strobe_d = 1'b0;
        case (state_q)
            HPC_ST_RESET: begin
                int_d = HPC_INT_RST;
                rdy_d = HPC_RDY_RST;
                sel_d = HPC_SEL_RST;
                if (device_reset_in) begin
                    state_d = HPC_ST_SAMPLE;
                end
            end
            HPC_ST_SAMPLE: begin
                sel_d   = host_port_select_strap;
                state_d = HPC_ST_RUN;
            end
            HPC_ST_RUN: begin
                // Strap is not looked at here
                if (sel_q) begin
                    int_d    = core_interrupt;
                    rdy_d    = core_ready;
                    doe_d    = core_data_oe;
                    dout_d   = core_data_out;
                    strobe_d = host_strobe_in;
                end else begin
                    rdy_d    = 1'b0;
                    strobe_d = 1'b0;
                end
            end
            default: begin
                state_d = HPC_ST_RESET;
            end
        endcase
        if (!device_reset_in) begin
            state_d  = HPC_ST_RESET;
            int_d    = HPC_INT_RST;
            doe_d    = 1'b0;
            strobe_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q  <= HPC_ST_RESET;
            sel_q    <= HPC_SEL_RST;
            int_q    <= HPC_INT_RST;
            rdy_q    <= HPC_RDY_RST;
            dout_q   <= '0;
            doe_q    <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            sel_q    <= sel_d;
            int_q    <= int_d;
            rdy_q    <= rdy_d;
            dout_q   <= dout_d;
            doe_q    <= doe_d;
            strobe_q <= strobe_d;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    wire in_reset = (state_q == HPC_ST_RESET);
    wire deselect = ~sel_q & (state_q == HPC_ST_RUN);

    assign port_selected        = sel_q;
    assign host_strobe_seen     = strobe_q;
    assign host_input_pullup_en = deselect;
    assign strap_pulldown_en    = ~device_reset_in;
    assign hold_on              = holder_sw_enable | deselect;

    assign host_ready_out     = rdy_q;
    assign host_ready_oe      = ~off_cond & sel_q & ~in_reset;
    assign host_interrupt_out = int_q;
    assign host_interrupt_oe  = ~off_cond & (in_reset | sel_q);
    assign host_data_lines_out = dout_q;
    assign host_data_lines_oe  = doe_q & ~off_cond;

    hpc_bus_holder #(
        .W (DATA_W)
    ) u_holder (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .hold_en   (hold_on & ~off_cond),
        .pad_oe    (host_data_lines_oe),
        .pad_level (host_data_lines_out),
        .hold_val  (host_data_hold_val),
        .hold_oe   (host_data_hold_oe)
    );

endmodule

`default_nettype wire
